// ---- src/dric_defs.vh ----
`ifndef DRIC_DEFS_VH
`define DRIC_DEFS_VH

// Depth of the reset release synchroniser, in flip-flops.
`define DRIC_SYNC_STAGES 2
// Reset value of the clock RAM invalid flag after a master reset.
`define DRIC_RAM_INVALID_RST 1'h1
// Reset value of the internal configuration word.
`define DRIC_CFG_RST 8'h00
// Reset value of the real-time clock seconds counter.
`define DRIC_RTC_RST 32'h0000_0000
// Encoding of the power state machine.
`define DRIC_ST_RESET 2'h0
`define DRIC_ST_RUN 2'h1
`define DRIC_ST_OFF 2'h2

`endif

// ---- src/dric_sync.v ----
`timescale 1ns/100ps
`include "dric_defs.vh"

// Two-stage synchroniser for a pin that comes from outside the clock domain.
module dric_sync (
    input  wire clk_i,
    input  wire d_i,
    output wire q_o
);
    reg stage_a;
    reg stage_b;

    // The first stage feeds only the second, to contain metastability.
    always @(posedge clk_i) begin
        stage_a <= d_i;
        stage_b <= stage_a;
    end

    assign q_o = stage_b;
endmodule // dric_sync

// ---- src/dric_top.v ----
// Summary of operation
// - Warm reset input acts as supply-good reset.
// - Warm reset alone keeps clock RAM invalid flag.
// - Warm reset alone enters deep power-off mode.
// - Master reset clears clock and configuration registers.
// - Master reset takes priority over warm reset.
`timescale 1ns/100ps
`include "dric_defs.vh"

module dric_top (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        warm_hw_reset_n_i,
    input  wire        master_power_on_reset_n_i,
    input  wire        ram_invalid_clear_i,
    input  wire        cfg_we_i,
    input  wire [7:0]  cfg_wdata_i,
    input  wire        rtc_tick_i,
    input  wire        wake_i,
    output reg         supply_ok_indication_o,
    output reg         core_reset_n_o,
    output reg         master_reset_n_o,
    output reg         power_off_o,
    output reg         ram_invalid_o,
    output reg  [7:0]  cfg_o,
    output reg  [31:0] rtc_count_o
);
    // The block turns the two board reset pins into the internal resets
    // and the power state. Three states are used: reset, run and off.
    // A master reset drives reset, clears the retained state and wins over
    // anything else. A warm reset on its own drives off, where the core is
    // held in reset but the clock, the configuration and the invalid flag
    // survive. Off is left on a master reset, or when the warm pin is released
    // and a wake request arrives, but the core reset is released as soon as both pins are, wake or not.
    //
    // Both pins are asynchronous to clk_i and reach the logic only through
    // two-stage synchronisers. Every effect of a pin therefore shows three
    // edges after the pin moves; the system reset reset_n_i is already in
    // the clock domain and acts on the next edge. A pin pulse shorter than
    // a clock period may be missed, which the board supervisor never makes.

    // State codes of the power sequencer, plain binary.
    localparam [1:0] ST_RESET = `DRIC_ST_RESET;
    localparam [1:0] ST_RUN   = `DRIC_ST_RUN;
    localparam [1:0] ST_OFF   = `DRIC_ST_OFF;

    // Synchronised copies of the two reset pins, high while released.
    wire        warm_sync;
    wire        master_sync;

    // Power state and its next value; the state only moves on an edge
    // and always starts from reset after the system reset.
    reg  [1:0]  state;
    reg  [1:0]  next_state;

    // Next values of the status outputs.
    reg         next_supply_ok;
    reg         next_core_reset_n;
    reg         next_master_reset_n;
    reg         next_power_off;

    // Next values of the state kept across a warm reset.
    reg         next_ram_invalid;
    reg  [7:0]  next_cfg;
    reg  [31:0] next_rtc_count;

    // True when both pins are released; decoded by the sequencer and by
    // the core reset, so it lives in one place.
    function both_released;
        input warm_n;
        input master_n;
        begin
            both_released = warm_n && master_n;
        end
    endfunction

    // True when only the warm reset is asserted, the power-off request.
    function warm_only;
        input warm_n;
        input master_n;
        begin
            warm_only = master_n && !warm_n;
        end
    endfunction

    // True while the master reset is asserted; it is tested in every
    // state and in the retained logic, so it is decoded once here.
    function master_held;
        input master_n;
        begin
            master_held = !master_n;
        end
    endfunction

    // Each pin passes two flip-flops before any logic reads it; nothing
    // but the second stage looks at the first.
    dric_sync u_warm_sync (
        .clk_i (clk_i),
        .d_i   (warm_hw_reset_n_i),
        .q_o   (warm_sync)
    );

    dric_sync u_master_sync (
        .clk_i (clk_i),
        .d_i   (master_power_on_reset_n_i),
        .q_o   (master_sync)
    );

    // Master reset outranks warm reset, and a warm reset alone ends in
    // power-off from any state. Short of a master reset, leaving power-off needs
    // the warm pin released and a wake request, so a glitch on the pin alone cannot
    // end power-off; the core reset still follows the pin alone.
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: begin
                // Leave reset once the master pin is released.
                if (master_held(master_sync)) begin
                    next_state = ST_RESET;
                end else if (warm_only(warm_sync, master_sync)) begin
                    next_state = ST_OFF;
                end else begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // A master reset is tested first so that it always wins.
                if (master_held(master_sync)) begin
                    next_state = ST_RESET;
                end else if (warm_only(warm_sync, master_sync)) begin
                    next_state = ST_OFF;
                end
            end
            ST_OFF: begin
                // Only a master reset, or the wake request with both pins released, leaves off; the clock keeps running.
                if (master_held(master_sync)) begin
                    next_state = ST_RESET;
                end else if (both_released(warm_sync, master_sync) &&
                             wake_i) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RESET;
            end
        endcase
    end

    // Status outputs follow the synchronised pins. Reading the raw pins
    // would assert the core reset two edges sooner, but a pin caught in
    // mid-swing could then leave the core reset metastable; the two extra
    // edges are the price of a clean assert and release.
    always @* begin
        next_supply_ok      = warm_sync;
        next_core_reset_n   = both_released(warm_sync,
                                            master_sync);
        next_master_reset_n = !master_held(master_sync);
        next_power_off      = (next_state == ST_OFF);
    end

    // Status registers. The system reset holds both internal resets low
    // and power-off clear, so the sequencer always starts from reset and
    // never leaves a stale power-off level on its output.
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            state                  <= ST_RESET;
            supply_ok_indication_o <= 1'h0;
            core_reset_n_o         <= 1'h0;
            master_reset_n_o       <= 1'h0;
            power_off_o            <= 1'h0;
        end else begin
            state                  <= next_state;
            supply_ok_indication_o <= next_supply_ok;
            core_reset_n_o         <= next_core_reset_n;
            master_reset_n_o       <= next_master_reset_n;
            power_off_o            <= next_power_off;
        end
    end

    // Retained state. Only a master reset or the system reset clears it; a warm reset leaves
    // the flag, the configuration and the clock alone, so time keeps
    // counting through a power-off.
    always @* begin
        next_ram_invalid = ram_invalid_o;
        next_cfg         = cfg_o;
        next_rtc_count   = rtc_count_o;
        if (master_held(master_sync)) begin
            // Setting the flag beats a clear in the same cycle, so a fresh
            // power-up is never taken for valid clock RAM contents.
            next_ram_invalid = `DRIC_RAM_INVALID_RST;
            next_cfg         = `DRIC_CFG_RST;
            next_rtc_count   = `DRIC_RTC_RST;
        end else begin
            if (ram_invalid_clear_i) begin
                next_ram_invalid = 1'h0;
            end
            // A write outside the running state is dropped on purpose.
            if (cfg_we_i && state == ST_RUN) begin
                next_cfg = cfg_wdata_i;
            end
            if (rtc_tick_i) begin
                next_rtc_count = rtc_count_o + 32'h0000_0001;
            end
        end
    end

    // The retained registers. The system reset sets them to their reset
    // values as well, so a run always starts from a cleared clock and a
    // flag that marks the clock RAM as not yet valid.
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            ram_invalid_o <= `DRIC_RAM_INVALID_RST;
            cfg_o         <= `DRIC_CFG_RST;
            rtc_count_o   <= `DRIC_RTC_RST;
        end else begin
            ram_invalid_o <= next_ram_invalid;
            cfg_o         <= next_cfg;
            rtc_count_o   <= next_rtc_count;
        end
    end

endmodule // dric_top

// ---- verification/dric_supervisor.sv ----
`timescale 1ns/100ps
// Board supervisor: power-up pulls both pins low, a supply dip only warm.
module dric_supervisor (
    input  wire power_up_i,
    input  wire supply_drop_i,
    output wire master_power_on_reset_n_o,
    output wire warm_hw_reset_n_o
);
    // Pins move off the edge, since the supervisor has no clock of its own.
    assign #7 master_power_on_reset_n_o = ~power_up_i;
    assign #7 warm_hw_reset_n_o = ~(power_up_i | supply_drop_i);
endmodule // dric_supervisor

// ---- verification/dric_top_properties.sv ----
`timescale 1ns/100ps
`include "dric_defs.vh"
module dric_top_properties (
    input wire        clk_i,
    input wire        reset_n_i,
    input wire        warm_hw_reset_n_i,
    input wire        master_power_on_reset_n_i,
    input wire        supply_ok_indication_o,
    input wire        core_reset_n_o,
    input wire        master_reset_n_o,
    input wire        power_off_o,
    input wire        ram_invalid_o,
    input wire [7:0]  cfg_o,
    input wire [31:0] rtc_count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Pins need two edges to pass the synchroniser and a third before outputs follow.
    supply_good_a: assert property (
        warm_hw_reset_n_i[*3] |=> supply_ok_indication_o)
        else $error("supply good missing");
    core_hold_a: assert property (
        (!warm_hw_reset_n_i)[*3] |=> !core_reset_n_o)
        else $error("core not held in reset");
    flag_kept_a: assert property (
        master_power_on_reset_n_i[*3] |=> !$rose(ram_invalid_o))
        else $error("invalid flag set");
    warm_off_a: assert property (
        (!warm_hw_reset_n_i && master_power_on_reset_n_i)[*3]
        |=> power_off_o) else $error("no off");
    master_clear_a: assert property (
        (!master_power_on_reset_n_i)[*3] |=> cfg_o == `DRIC_CFG_RST &&
        rtc_count_o == `DRIC_RTC_RST) else $error("state not cleared");
    master_out_a: assert property (
        (!master_power_on_reset_n_i)[*3] |=> !master_reset_n_o)
        else $error("master reset not shown");
    master_wins_a: assert property (
        (!master_power_on_reset_n_i)[*3] |=> !power_off_o && ram_invalid_o)
        else $error("master lost");
    sync_release_a: assert property (
        $rose(core_reset_n_o) |-> $past(warm_hw_reset_n_i, 3) &&
        $past(master_power_on_reset_n_i, 3)) else $error("early release");
endmodule // dric_top_properties
bind dric_top dric_top_properties u_dric_top_properties (.*);

// ---- verification/test_dric_top.sv ----
`timescale 1ns/100ps
`include "dric_defs.vh"
module test_dric_top;
    reg clk_i = 0, reset_n_i = 0, pu = 1, drop = 0, ram_invalid_clear_i = 0;
    reg cfg_we_i = 0, rtc_tick_i = 0, wake_i = 0;
    reg [7:0] cfg_wdata_i = 8'h00, ecfg = 8'h00;
    reg [16:0] lf = 17'h11d0c;
    reg [31:0] ert = 32'h0;
    integer n_mismatch = 0, compares = 0, cyc = 0;
    wire warm_hw_reset_n_i, master_power_on_reset_n_i, supply_ok_indication_o;
    wire core_reset_n_o, master_reset_n_o, power_off_o, ram_invalid_o;
    wire [7:0] cfg_o;
    wire [31:0] rtc_count_o;
    dric_top u_dric_top (.*);
    dric_supervisor u_dric_supervisor (.power_up_i(pu), .supply_drop_i(drop),
        .master_power_on_reset_n_o(master_power_on_reset_n_i),
        .warm_hw_reset_n_o(warm_hw_reset_n_i));
    // Clock at 40 MHz.
    always #12.5 clk_i = ~clk_i;
    function [16:0] nx(input [16:0] v); nx = {v[15:0], v[16] ^ v[13]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp); begin
        compares = compares + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %0t output differs", $time);
        end
    end endtask
    task step(input integer n); begin repeat (n) @(posedge clk_i); #2; end
    endtask
    task summarize; begin
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end endtask
    // A hang is cut short well past the few hundred cycles the run needs.
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin n_mismatch = n_mismatch + 1; summarize; end
    end
    // Power-up, random traffic, supply dip, wake out of off, then master reset.
    initial begin
        step(10);
        reset_n_i = 1;
        step(4);
        chk(power_off_o, 1'h0);
        chk(ram_invalid_o, 1'h1);
        chk(rtc_count_o, `DRIC_RTC_RST);
        chk(master_reset_n_o, 1'h0);
        pu = 0;
        step(1);
        chk(core_reset_n_o, 1'h0);
        step(3);
        chk(core_reset_n_o, 1'h1);
        chk(master_reset_n_o, 1'h1);
        repeat (200) begin
            lf = nx(lf);
            {wake_i, rtc_tick_i, cfg_we_i, cfg_wdata_i} = lf[10:0];
            if (cfg_we_i) ecfg = cfg_wdata_i;
            ert = ert + rtc_tick_i;
            step(1);
        end
        {wake_i, rtc_tick_i, cfg_we_i, ram_invalid_clear_i} = 4'h1;
        step(1);
        ram_invalid_clear_i = 0;
        chk(cfg_o, ecfg);
        chk(rtc_count_o, ert);
        drop = 1;
        step(4);
        chk(power_off_o, 1'h1);
        chk(supply_ok_indication_o, 1'h0);
        chk(core_reset_n_o, 1'h0);
        chk(ram_invalid_o, 1'h0);
        // Corner: a write while powered off must be dropped.
        {cfg_we_i, cfg_wdata_i} = {1'h1, ~ecfg};
        step(1);
        cfg_we_i = 0;
        chk(cfg_o, ecfg);
        {drop, wake_i} = 2'h1;
        step(4);
        chk(power_off_o, 1'h0);
        chk(supply_ok_indication_o, 1'h1);
        chk(rtc_count_o, ert);
        // Corner: a flag clear during a master reset must lose.
        {pu, wake_i, ram_invalid_clear_i} = 3'h5;
        step(4);
        ram_invalid_clear_i = 0;
        chk(power_off_o, 1'h0);
        chk(ram_invalid_o, 1'h1);
        chk(cfg_o, `DRIC_CFG_RST);
        chk(rtc_count_o, `DRIC_RTC_RST);
        chk(master_reset_n_o, 1'h0);
        summarize;
    end
endmodule // test_dric_top
